/* rtl/orb_pkg.sv */
// Constants, types and field layouts of the on-chip RAM access block.
// Assumes a single core clock and a synchronous active-low reset.
package orb_pkg;

  // ****************************************************************
  // Address layout
  // ****************************************************************
  localparam int          ADDR_W      = 32;
  localparam int          BASE_W      = 22;   // Base field, bits [31:10]
  localparam int          SEL_W       = 6;    // Select field, bits [15:10]
  localparam int          SEL_LSB     = 10;
  localparam int          SEL_MSB     = 15;
  localparam int          LINE_LSB    = 5;
  localparam int          LINE_MSB    = 9;
  localparam int          PAGE_W      = 2;    // Pages 0A, 0B, 1A, 1B
  localparam int          PAGE_PAIR   = 1;    // Index bit picking pair 0 or 1
  localparam logic [31:0] NARROW_MASK = 32'h1fff_ffff;  // Bits [28:0]
  localparam logic [4:0]  LINE_ZERO   = 5'h00;
  localparam logic [5:0]  BLOCK_BYTES = 6'h20;

  // ****************************************************************
  // Bus indices and wait figures
  // ****************************************************************
  localparam int          NBUS        = 3;
  localparam int          BUS_OPER    = 0;    // Highest priority on conflict
  localparam int          BUS_IFETCH  = 1;
  localparam int          BUS_SYS     = 2;
  localparam logic [1:0]  WAIT_NONE   = 2'h0;
  localparam logic [1:0]  WAIT_CRBUS  = 2'h1;
  localparam logic [1:0]  WAIT_XPAGE  = 2'h2;

  typedef enum logic [1:0] {
    TGT_OTHER = 2'b00,
    TGT_OL    = 2'b01,
    TGT_IL    = 2'b10
  } orb_tgt_e;

  typedef enum logic {
    BLK_IDLE = 1'b0,
    BLK_XFER = 1'b1
  } orb_blk_e;

endpackage

/* rtl/orb_ram_access.sv */
// On-chip operand-local and instruction-local RAM access control with
// the 32-byte block transfer engine to external memory.
// Assumes every input comes from logic on i_clock; the RAM arrays, the
// translation buffer and the external memory port sit outside.
//
// How it works
// - Fetches to operand RAM take crossbus, multi-cycle
// - Instruction RAM same-page fetch finishes in one
// - Operand RAM same-page read finishes in one
// - Operand RAM write one cycle absent conflict
// - Operand accesses to instruction RAM multi-cycle
// - Prefetch to operand RAM starts inbound transfer
// - Write-back to operand RAM starts outbound transfer
// - Transfers move 32 aligned bytes
// - Stall only on the page under transfer
// - Translated address: ppn, va[9:5], zeros
// - Cacheability attributes ignored for operand RAM
// - Transfer instructions checked as reads
// - Translation exception suppresses the transfer
// - Untranslated prefetch source from source register
// - Untranslated write-back target from destination register
// - Select bits choose per-bit for [15:10]
// - User access disallowed raises address error
// - Protected mode applies ordinary translation checks
// - Same-page conflicts arbitrated, all complete
// - Page change costs at most two waits
// - No system master access during sleep
// - Extended mode widens base to [31:10]
// - Select zero passes va, one passes register
`timescale 1ns/1ps

module orb_ram_access
  import orb_pkg::*;
(
  input  wire logic              i_clock,
  input  wire logic              i_rst_n,
  // Mode and protection
  input  wire logic              i_translation_enable,
  input  wire logic              i_ram_protect_enable,
  input  wire logic              i_user_access_allow,
  input  wire logic              i_privileged_mode_flag,
  input  wire logic              i_ext_addr_mode,
  input  wire logic              i_sleep_mode,
  // Block transfer address registers
  input  wire logic [BASE_W-1:0] i_page0_src_base,
  input  wire logic [SEL_W-1:0]  i_page0_src_select,
  input  wire logic [BASE_W-1:0] i_page1_src_base,
  input  wire logic [SEL_W-1:0]  i_page1_src_select,
  input  wire logic [BASE_W-1:0] i_page0_dst_base,
  input  wire logic [SEL_W-1:0]  i_page0_dst_select,
  input  wire logic [BASE_W-1:0] i_page1_dst_base,
  input  wire logic [SEL_W-1:0]  i_page1_dst_select,
  // Operand bus (CPU and FPU)
  input  wire logic              i_oper_req,
  input  wire logic              i_oper_write,
  input  wire logic [1:0]        i_oper_tgt,
  input  wire logic [PAGE_W-1:0] i_oper_page,
  output logic                   o_oper_ready,
  output logic                   o_oper_via_crbus,
  output logic                   o_oper_addr_err,
  output logic                   o_oper_mmu_check,
  // Instruction bus
  input  wire logic              i_ifetch_req,
  input  wire logic [1:0]        i_ifetch_tgt,
  input  wire logic [PAGE_W-1:0] i_ifetch_page,
  output logic                   o_ifetch_ready,
  output logic                   o_ifetch_via_crbus,
  output logic                   o_ifetch_addr_err,
  output logic                   o_ifetch_mmu_check,
  // On-chip system bus master, physical address
  input  wire logic              i_sys_req,
  input  wire logic [1:0]        i_sys_tgt,
  input  wire logic [PAGE_W-1:0] i_sys_page,
  output logic                   o_sys_ready,
  output logic                   o_sys_refused,
  // Prefetch / write-back issue to the operand RAM region
  input  wire logic              i_blk_req,
  input  wire logic              i_blk_write,
  input  wire logic [ADDR_W-1:0] i_blk_vaddr,
  input  wire logic [PAGE_W-1:0] i_blk_page,
  input  wire logic              i_tlb_hit,
  input  wire logic              i_tlb_read_ok,
  input  wire logic [BASE_W-1:0] i_tlb_ppn,
  output logic                   o_blk_accept,
  output logic                   o_blk_busy,
  output logic                   o_tlb_miss,
  output logic                   o_prot_err,
  // External memory side
  output logic                   o_ext_req,
  output logic                   o_ext_write,
  output logic [ADDR_W-1:0]      o_ext_addr,
  output logic [5:0]             o_ext_len,
  output logic                   o_ext_uncached,
  input  wire logic              i_ext_done
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [NBUS-1:0]             pend;
    logic [NBUS-1:0][1:0]        wcnt;
    logic [NBUS-1:0][PAGE_W-1:0] last_page;
    logic [NBUS-1:0][1:0]        last_tgt;
    orb_blk_e                    blk_st;
    logic [PAGE_W-1:0]           blk_page;
    logic                        blk_write;
    logic [ADDR_W-1:0]           ext_addr;
    logic                        accept;
    logic                        tlb_miss;
    logic                        prot_err;
  } orb_state_s;

  orb_state_s st;
  orb_state_s next_st;

  // Base with per-bit select over [15:10], then address width cut
  function automatic logic [ADDR_W-1:0] orb_phys(input logic [BASE_W-1:0] base,
                                                 input logic [SEL_W-1:0]  sel,
                                                 input logic [ADDR_W-1:0] va,
                                                 input logic              ext);
    logic [ADDR_W-1:0] a;
    a = {base, va[LINE_MSB:LINE_LSB], LINE_ZERO};
    for (int i = 0; i < SEL_W; i++) begin
      a[SEL_LSB+i] = sel[i] ? base[i] : va[SEL_LSB+i];
    end
    return ext ? a : (a & NARROW_MASK);
  endfunction

  // ****************************************************************
  // Access arbitration and wait control
  // ****************************************************************
  logic [NBUS-1:0]             req;
  logic [NBUS-1:0][1:0]        tgt;
  logic [NBUS-1:0][PAGE_W-1:0] page;
  logic [NBUS-1:0]             hold;
  logic [NBUS-1:0]             uerr;
  logic [NBUS-1:0]             rdy;
  logic [NBUS-1:0][1:0]        need;
  logic                        mmu_on;
  logic                        blk_fault;
  logic [ADDR_W-1:0]           blk_addr;

  assign mmu_on = i_translation_enable && i_ram_protect_enable;

  always_comb begin
    req  = {i_sys_req, i_ifetch_req, i_oper_req};
    tgt  = {i_sys_tgt, i_ifetch_tgt, i_oper_tgt};
    page = {i_sys_page, i_ifetch_page, i_oper_page};
    for (int b = 0; b < NBUS; b++) begin
      // Page under transfer stalls, others proceed
      hold[b] = (st.blk_st == BLK_XFER) && (tgt[b] == TGT_OL)
              && (page[b] == st.blk_page);
      // Lower priority bus waits out a same-page collision
      for (int a = 0; a < b; a++) begin
        if (req[a] && (tgt[a] == tgt[b]) && (page[a] == page[b])
            && (tgt[b] != TGT_OTHER)) begin
          hold[b] = 1'b1;
        end
      end
      uerr[b] = (b != BUS_SYS) && (tgt[b] != TGT_OTHER)
              && !i_privileged_mode_flag && !i_user_access_allow;
      // Waits before first completion chance
      if (tgt[b] == TGT_OTHER || b == BUS_SYS || uerr[b]) begin
        need[b] = WAIT_NONE;
      end else if ((b == BUS_IFETCH && tgt[b] == TGT_OL)
                   || (b == BUS_OPER && tgt[b] == TGT_IL)) begin
        need[b] = WAIT_CRBUS;
      end else if ((b == BUS_OPER && i_oper_write) || ((st.last_tgt[b] == tgt[b])
                   && (st.last_page[b] == page[b]))) begin
        need[b] = WAIT_NONE;
      end else begin
        need[b] = WAIT_XPAGE;
      end
    end
    hold[BUS_SYS] = hold[BUS_SYS] || i_sleep_mode;
    for (int b = 0; b < NBUS; b++) begin
      rdy[b] = req[b] && !hold[b] && (st.pend[b] ? (st.wcnt[b] == WAIT_NONE)
                                                : (need[b] == WAIT_NONE));
      if (uerr[b]) begin
        rdy[b] = req[b];
      end
    end
  end

  // ****************************************************************
  // Block transfer address and fault check
  // ****************************************************************
  always_comb begin
    // Prefetch and write-back both check as reads
    blk_fault = mmu_on && !(i_tlb_hit && i_tlb_read_ok);
    if (mmu_on) begin
      blk_addr = orb_phys(i_tlb_ppn, {SEL_W{1'b1}}, i_blk_vaddr,
                          i_ext_addr_mode);
    end else if (!i_blk_write) begin
      blk_addr = i_blk_page[PAGE_PAIR]
               ? orb_phys(i_page1_src_base, i_page1_src_select, i_blk_vaddr,
                          i_ext_addr_mode)
               : orb_phys(i_page0_src_base, i_page0_src_select, i_blk_vaddr,
                          i_ext_addr_mode);
    end else begin
      blk_addr = i_blk_page[PAGE_PAIR]
               ? orb_phys(i_page1_dst_base, i_page1_dst_select, i_blk_vaddr,
                          i_ext_addr_mode)
               : orb_phys(i_page0_dst_base, i_page0_dst_select, i_blk_vaddr,
                          i_ext_addr_mode);
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_st          = st;
    next_st.accept   = 1'b0;
    next_st.tlb_miss = 1'b0;
    next_st.prot_err = 1'b0;
    for (int b = 0; b < NBUS; b++) begin
      if (rdy[b]) begin
        next_st.pend[b]      = 1'b0;
        next_st.wcnt[b]      = WAIT_NONE;
        next_st.last_page[b] = page[b];
        next_st.last_tgt[b]  = uerr[b] ? TGT_OTHER : tgt[b];
      end else if (req[b] && !st.pend[b]) begin
        next_st.pend[b] = 1'b1;
        next_st.wcnt[b] = (need[b] == WAIT_NONE) ? WAIT_NONE : need[b] - 2'h1;
      end else if (st.pend[b] && st.wcnt[b] != WAIT_NONE) begin
        next_st.wcnt[b] = st.wcnt[b] - 2'h1;
      end
    end
    unique case (st.blk_st)
      BLK_IDLE: begin
        if (i_blk_req && blk_fault) begin
          next_st.tlb_miss = !i_tlb_hit;
          next_st.prot_err = i_tlb_hit;
        end else if (i_blk_req) begin
          next_st.blk_st    = BLK_XFER;
          next_st.accept    = 1'b1;
          next_st.blk_write = i_blk_write;
          next_st.blk_page  = i_blk_page;
          next_st.ext_addr  = blk_addr;
        end
      end
      BLK_XFER: begin
        if (i_ext_done) begin
          next_st.blk_st = BLK_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_oper_ready       = rdy[BUS_OPER];
  assign o_ifetch_ready     = rdy[BUS_IFETCH];
  assign o_sys_ready        = rdy[BUS_SYS];
  assign o_oper_addr_err    = i_oper_req && uerr[BUS_OPER];
  assign o_ifetch_addr_err  = i_ifetch_req && uerr[BUS_IFETCH];
  assign o_oper_via_crbus   = i_oper_req && (i_oper_tgt == TGT_IL);
  assign o_ifetch_via_crbus = i_ifetch_req && (i_ifetch_tgt == TGT_OL);
  assign o_oper_mmu_check   = i_oper_req && mmu_on && (i_oper_tgt != TGT_OTHER);
  assign o_ifetch_mmu_check = i_ifetch_req && mmu_on && (i_ifetch_tgt != TGT_OTHER);
  assign o_sys_refused      = i_sys_req && i_sleep_mode;
  assign o_blk_accept       = st.accept;
  assign o_blk_busy         = (st.blk_st == BLK_XFER);
  assign o_tlb_miss         = st.tlb_miss;
  assign o_prot_err         = st.prot_err;
  assign o_ext_req          = (st.blk_st == BLK_XFER);
  assign o_ext_write        = st.blk_write;
  assign o_ext_addr         = st.ext_addr;
  assign o_ext_len          = BLOCK_BYTES;
  // Translation cache attributes are never consulted here
  assign o_ext_uncached     = 1'b1;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_CRBUS_MULTI: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_ifetch_req && i_ifetch_tgt == TGT_OL && !st.pend[BUS_IFETCH] && !uerr[BUS_IFETCH]
    |-> !o_ifetch_ready) else $error("crossbus fetch done in one cycle");
  AST_OPER_IL_MULTI: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_oper_req && i_oper_tgt == TGT_IL && !st.pend[BUS_OPER] && !uerr[BUS_OPER]
    |-> !o_oper_ready) else $error("operand to IL done in one cycle");
  AST_WRITE_FAST: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_oper_req && i_oper_write && i_oper_tgt == TGT_OL && !st.pend[BUS_OPER]
    && !hold[BUS_OPER] |-> o_oper_ready) else $error("write not one cycle");
  AST_READ_SAME_PAGE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_oper_req && !i_oper_write && i_oper_tgt == TGT_OL && !st.pend[BUS_OPER]
    && st.last_tgt[BUS_OPER] == TGT_OL && st.last_page[BUS_OPER] == i_oper_page
    && !hold[BUS_OPER] |-> o_oper_ready) else $error("same-page read waited");
  AST_XPAGE_BOUND: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_ifetch_req && !st.pend[BUS_IFETCH] && !hold[BUS_IFETCH] && !o_ifetch_ready
    ##1 (i_ifetch_req && !hold[BUS_IFETCH]) [*2] |-> o_ifetch_ready)
    else $error("more than two waits");
  AST_SLEEP_BLOCK: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_sleep_mode |-> !o_sys_ready) else $error("system access in sleep");
  AST_FAULT_SUPPRESS: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_blk_req && !o_blk_busy && blk_fault |=> !o_ext_req && (o_tlb_miss || o_prot_err))
    else $error("faulted transfer started");
  AST_ALIGN: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_ext_req |-> o_ext_addr[4:0] == LINE_ZERO && o_ext_len == BLOCK_BYTES)
    else $error("transfer not aligned");
  AST_PAGE_STALL: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_blk_busy && i_oper_req && i_oper_tgt == TGT_OL && i_oper_page == st.blk_page
    && !uerr[BUS_OPER] |-> !o_oper_ready) else $error("busy page accessed");
  AST_CONFLICT_LOSER: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_oper_req && i_ifetch_req && i_oper_tgt == i_ifetch_tgt && i_oper_tgt != TGT_OTHER
    && i_oper_page == i_ifetch_page && !uerr[BUS_IFETCH] |-> !o_ifetch_ready)
    else $error("conflict not arbitrated");
  AST_START: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_blk_req && !o_blk_busy && !blk_fault |=> o_ext_req && o_blk_accept
    && o_ext_write == $past(i_blk_write) && o_ext_addr == $past(blk_addr))
    else $error("transfer did not start");
  AST_USER_ERR: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_oper_req && i_oper_tgt == TGT_OL && !i_privileged_mode_flag && !i_user_access_allow
    |-> o_oper_addr_err && o_oper_ready) else $error("user access not trapped");
  AST_NARROW: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_blk_req && !o_blk_busy && !blk_fault && !i_ext_addr_mode
    |=> o_ext_addr[31:29] == 3'h0) else $error("narrow mode high bits");

  COV_PREFETCH: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    o_blk_accept && !o_ext_write ##[1:20] i_ext_done);
  COV_WRITEBACK: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    o_blk_accept && o_ext_write);
  COV_CONFLICT: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    hold[BUS_IFETCH] && i_oper_req ##[1:4] o_ifetch_ready);
  COV_TLB_MISS: cover property (@(posedge i_clock) disable iff (!i_rst_n) o_tlb_miss);

endmodule // orb_ram_access

/* verif/orb_ext_mem.sv */
// Behavioural external memory that answers 32-byte block transfers.
// Assumes the block holds o_ext_req high until it sees the done pulse.
`timescale 1ns/1ps

module orb_ext_mem (
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic       i_ext_req,
  input  wire logic [3:0] i_delay,
  output logic            o_ext_done
);
  // ****************
  // Response timing
  // ****************
  logic [3:0] cnt;
  logic       sent;

  // One pulse per request; a request still held never earns a second
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || !i_ext_req) begin
      cnt <= 4'h0;
      sent <= 1'b0;
      o_ext_done <= 1'b0;
    end else if (!sent && cnt == i_delay) begin
      sent <= 1'b1;
      o_ext_done <= 1'b1;
    end else begin
      cnt <= cnt + 4'h1;
      o_ext_done <= 1'b0;
    end
  end
endmodule // orb_ext_mem

/* verif/tb_top.sv */
// Self-checking bench for the on-chip RAM access block.
// Assumes orb_pkg, orb_ram_access and orb_ext_mem are compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end

module tb_top
  import orb_pkg::*;
;
  // ****************
  // Signals
  // ****************
  logic        i_clock, i_rst_n, i_translation_enable, i_ram_protect_enable, i_sleep_mode;
  logic        i_user_access_allow, i_privileged_mode_flag, i_ext_addr_mode, i_oper_write;
  logic        i_blk_req, i_blk_write, i_tlb_hit, i_tlb_read_ok, i_ext_done;
  logic [21:0] i_page0_src_base, i_page1_src_base, i_page0_dst_base, i_page1_dst_base;
  logic [21:0] i_tlb_ppn;
  logic [5:0]  i_page0_src_select, i_page1_src_select, i_page0_dst_select, i_page1_dst_select;
  logic [31:0] i_blk_vaddr, o_ext_addr;
  logic [1:0]  i_blk_page, tgt [3], pg [3];
  logic [5:0]  o_ext_len;
  logic [3:0]  ext_delay;
  logic [2:0]  req;
  logic        o_oper_ready, o_oper_via_crbus, o_oper_addr_err, o_oper_mmu_check, o_sys_ready;
  logic        o_ifetch_ready, o_ifetch_via_crbus, o_ifetch_addr_err, o_ifetch_mmu_check;
  logic        o_sys_refused, o_blk_accept, o_blk_busy, o_tlb_miss, o_prot_err, o_ext_req;
  logic        o_ext_write, o_ext_uncached, busy_seen, err_seen, cr_seen, mmu_seen;
  int          failures = 0, total_checks = 0;

  orb_ram_access u_orb_ram_access (.*, .i_oper_req(req[0]), .i_oper_tgt(tgt[0]),
    .i_oper_page(pg[0]), .i_ifetch_req(req[1]), .i_ifetch_tgt(tgt[1]), .i_ifetch_page(pg[1]),
    .i_sys_req(req[2]), .i_sys_tgt(tgt[2]), .i_sys_page(pg[2]));
  orb_ext_mem u_orb_ext_mem (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_ext_req(o_ext_req),
    .i_delay(ext_delay), .o_ext_done(i_ext_done));

  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  // Whole run is a few hundred cycles; this only catches a hang
  initial begin
    repeat (5000) @(posedge i_clock);
    failures++;
    conclude();
  end

  // ****************
  // Tasks
  // ****************
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Bus 0 operand, 1 fetch, 2 system; ew below zero skips the wait count
  task automatic acc(input int b, input logic w, input logic [1:0] t, input logic [1:0] p,
                     input int ew);
    int n;
    logic [2:0] rdy;
    n = 0;
    @(posedge i_clock);
    req[b] <= 1'b1;
    tgt[b] <= t;
    pg[b] <= p;
    if (b == 0) i_oper_write <= w;
    do begin
      @(negedge i_clock);
      rdy = {o_sys_ready, o_ifetch_ready, o_oper_ready};
      n++;
    end while (rdy[b] !== 1'b1 && n < 20);
    busy_seen = o_blk_busy;
    err_seen = b ? o_ifetch_addr_err : o_oper_addr_err;
    cr_seen = b ? o_ifetch_via_crbus : o_oper_via_crbus;
    mmu_seen = b ? o_ifetch_mmu_check : o_oper_mmu_check;
    @(posedge i_clock);
    req[b] <= 1'b0;
    `CHK("ready", 1'b1, rdy[b])
    if (ew >= 0) `CHK("waits", ew, n - 1)
  endtask

  function automatic logic [31:0] exp_addr(logic w, logic [1:0] p, logic [31:0] va, logic m);
    logic [21:0] bs;
    logic [5:0]  s;
    logic [31:0] a;
    bs = w ? (p[1] ? i_page1_dst_base : i_page0_dst_base)
           : (p[1] ? i_page1_src_base : i_page0_src_base);
    s = w ? (p[1] ? i_page1_dst_select : i_page0_dst_select)
          : (p[1] ? i_page1_src_select : i_page0_src_select);
    a = {bs, va[9:5], 5'h00};
    for (int i = 0; i < 6; i++) if (!s[i]) a[10+i] = va[10+i];
    if (m) a = {i_tlb_ppn, va[9:5], 5'h00};
    if (!i_ext_addr_mode) a[31:29] = 3'h0;
    return a;
  endfunction

  task automatic blk(input logic w, input logic [1:0] p, input logic [31:0] va,
                     input logic hit, input logic rok, input logic [3:0] dly);
    logic m;
    logic f;
    @(posedge i_clock);
    i_blk_req <= 1'b1;
    i_blk_write <= w;
    i_blk_page <= p;
    i_blk_vaddr <= va;
    i_tlb_hit <= hit;
    i_tlb_read_ok <= rok;
    ext_delay <= dly;
    @(posedge i_clock);
    i_blk_req <= 1'b0;
    @(negedge i_clock);
    m = i_translation_enable & i_ram_protect_enable;
    f = m & !(hit & rok);
    `CHK("accept", !f, o_blk_accept)
    `CHK("tlb miss", m & !hit, o_tlb_miss)
    `CHK("prot err", m & hit & !rok, o_prot_err)
    `CHK("ext req", !f, o_ext_req)
    if (!f) `CHK("ext addr", exp_addr(w, p, va, m), o_ext_addr)
    if (!f) `CHK("ext dir", w, o_ext_write)
    if (!f) `CHK("ext len", 6'h20, o_ext_len)
  endtask

  task automatic idle();
    int n;
    n = 0;
    while (o_blk_busy !== 1'b0 && n < 40) begin
      @(negedge i_clock);
      n++;
    end
    `CHK("busy ends", 1'b0, o_blk_busy)
    `CHK("uncached", 1'b1, o_ext_uncached)
  endtask

  // ****************
  // Tests
  // ****************
  initial begin
    {i_rst_n, i_translation_enable, i_ram_protect_enable, i_sleep_mode, i_ext_addr_mode} = '0;
    {i_oper_write, i_blk_req, i_blk_write, i_tlb_hit, i_tlb_read_ok, i_blk_page} = '0;
    {i_privileged_mode_flag, i_user_access_allow} = 2'b11;
    req = '0;
    tgt = '{default: 2'h0};
    pg = '{default: 2'h0};
    i_blk_vaddr = '0;
    ext_delay = 4'h2;
    i_page0_src_base = 22'h2a5c3f;
    i_page1_src_base = 22'h15a3c0;
    i_page0_dst_base = 22'h3c0f5a;
    i_page1_dst_base = 22'h0f3a96;
    i_tlb_ppn = 22'h3e1234;
    {i_page0_src_select, i_page1_src_select, i_page0_dst_select, i_page1_dst_select} = '0;
    repeat (2) @(posedge i_clock);
    i_rst_n <= 1'b1;
    acc(0, 1'b0, TGT_OL, 2'h0, 2);
    acc(0, 1'b0, TGT_OL, 2'h0, 0);
    acc(0, 1'b0, TGT_OL, 2'h1, 2);
    acc(0, 1'b1, TGT_OL, 2'h3, 0);
    acc(1, 1'b0, TGT_IL, 2'h2, 2);
    acc(1, 1'b0, TGT_IL, 2'h2, 0);
    acc(1, 1'b0, TGT_OL, 2'h0, 1);
    `CHK("fetch crossbus", 1'b1, cr_seen)
    acc(0, 1'b0, TGT_IL, 2'h1, 1);
    `CHK("operand crossbus", 1'b1, cr_seen)
    acc(0, 1'b0, TGT_OL, 2'h1, 2);
    acc(2, 1'b0, TGT_OL, 2'h2, 0);
    @(posedge i_clock);
    i_sleep_mode <= 1'b1;
    req[2] <= 1'b1;
    tgt[2] <= TGT_IL;
    repeat (3) begin
      @(negedge i_clock);
      `CHK("sleep refusal", 2'b01, {o_sys_ready, o_sys_refused})
    end
    @(posedge i_clock);
    i_sleep_mode <= 1'b0;
    @(negedge i_clock);
    `CHK("wake", 2'b10, {o_sys_ready, o_sys_refused})
    @(posedge i_clock);
    req[2] <= 1'b0;
    fork
      acc(0, 1'b0, TGT_IL, 2'h3, -1);
      acc(1, 1'b0, TGT_IL, 2'h3, -1);
    join
    for (int i = 0; i < 3; i++) begin
      @(posedge i_clock);
      {i_privileged_mode_flag, i_user_access_allow} <= i[1:0];
      acc(0, 1'b0, TGT_OL, 2'h1, -1);
      `CHK("addr err", i == 0, err_seen)
      acc(1, 1'b0, TGT_IL, 2'h1, -1);
      `CHK("fetch addr err", i == 0, err_seen)
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge i_clock);
      {i_translation_enable, i_ram_protect_enable} <= i[1:0];
      acc(1, 1'b0, TGT_IL, 2'h0, -1);
      `CHK("mmu check", i == 3, mmu_seen)
      acc(0, 1'b0, TGT_OL, 2'h0, -1);
      `CHK("operand mmu check", i == 3, mmu_seen)
    end
    // Walk all seven legal select patterns once each, alternating direction; pair 0 takes four, pair 1 three
    for (int k = 0; k < 7; k++) begin
      @(posedge i_clock);
      {i_translation_enable, i_ram_protect_enable} <= 2'b00;
      {i_page0_src_select, i_page1_src_select, i_page0_dst_select, i_page1_dst_select} <=
        {4{6'h3f << k}};
      i_ext_addr_mode <= k[1];
      blk(k[0], k[2:1], 32'hfedc_ba9f ^ (k << 11), 1'b1, 1'b1, 4'h1);
      idle();
    end
    @(posedge i_clock);
    i_translation_enable <= 1'b1;
    blk(1'b1, 2'h2, 32'h0123_4567, 1'b1, 1'b1, 4'h0);
    idle();
    @(posedge i_clock);
    i_ram_protect_enable <= 1'b1;
    blk(1'b0, 2'h1, 32'hfedc_bbe3, 1'b1, 1'b1, 4'h3);
    idle();
    @(posedge i_clock);
    i_ext_addr_mode <= 1'b0;
    blk(1'b1, 2'h3, 32'h8765_43f1, 1'b1, 1'b1, 4'h0);
    idle();
    blk(1'b0, 2'h0, 32'h1234_5678, 1'b0, 1'b1, 4'h0);
    blk(1'b1, 2'h0, 32'h1234_5678, 1'b1, 1'b0, 4'h0);
    @(posedge i_clock);
    {i_translation_enable, i_ram_protect_enable} <= 2'b00;
    blk(1'b0, 2'h1, 32'h0000_0420, 1'b1, 1'b1, 4'hc);
    acc(0, 1'b0, TGT_OL, 2'h2, -1);
    `CHK("other page free", 1'b1, busy_seen)
    acc(0, 1'b0, TGT_OL, 2'h1, -1);
    `CHK("busy page stalls", 1'b0, busy_seen)
    conclude();
  end
endmodule // tb_top
